/* File: design/liugc_chan_out.sv */
// Purpose: Per-channel output stage: receive mute and line pin drive
// Assumes: Framer-side inputs are on clk
// Notes:   Data outputs are registered; enables follow the test bit
`timescale 1ns/1ps
module liugc_chan_out
	import liugc_pkg::*;
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic sys_rst,
	// Controls
	input  wire logic receive_mute_on_loss,
	input  wire logic receive_signal_loss,
	input  wire logic output_tristate_test,
	// Receive path
	input  wire logic rx_data,
	output logic      rx_framer_data,
	// Transmit line pins
	input  wire logic tx_pos_in,
	input  wire logic tx_neg_in,
	output logic      tx_pos_o,
	output logic      tx_neg_o,
	output logic      tx_pin_oe
);

	logic rx_out_reg;  // Data to framer
	logic rx_out_next;
	logic pos_reg;     // Positive rail
	logic pos_next;
	logic neg_reg;     // Negative rail
	logic neg_next;

	// Mute and pass-through
	always_comb begin
		rx_out_next = rx_data;
		if (receive_mute_on_loss && receive_signal_loss) begin
			rx_out_next = 1'b0;
		end
		pos_next = tx_pos_in;
		neg_next = tx_neg_in;
	end

	// Output registers
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rx_out_reg <= DATA_RST;
			pos_reg <= DATA_RST;
			neg_reg <= DATA_RST;
		end else begin
			rx_out_reg <= rx_out_next;
			pos_reg <= pos_next;
			neg_reg <= neg_next;
		end
	end

	assign rx_framer_data = rx_out_reg;
	assign tx_pos_o = pos_reg;
	assign tx_neg_o = neg_reg;
	// Released pins float; driving resumes the cycle the bit clears
	assign tx_pin_oe = ~output_tristate_test;

endmodule : liugc_chan_out

/* File: design/liugc_loss_det.sv */
// Purpose: Per-channel consecutive-zero counter declaring receive signal loss
// Assumes: Recovered data and its valid strobe arrive on clk
// Notes:   Counter saturates at the longer threshold, so no wrap
`timescale 1ns/1ps
module liugc_loss_det
	import liugc_pkg::*;
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic sys_rst,
	// Recovered receive bit
	input  wire logic rx_data,
	input  wire logic rx_valid,
	// Threshold choice
	input  wire logic extended_loss_threshold,
	// Loss state
	output logic      receive_signal_loss
);

	logic [12:0] zero_cnt_reg;   // Zeros seen in a row
	logic [12:0] zero_cnt_next;
	logic        loss_reg;       // Loss declared
	logic        loss_next;
	logic [12:0] limit;          // Active threshold

	// Threshold selection and counting
	always_comb begin
		limit = extended_loss_threshold ? LOSS_ZEROS_EXT : LOSS_ZEROS_NORM;
		zero_cnt_next = zero_cnt_reg;
		loss_next = loss_reg;
		if (rx_valid) begin
			if (rx_data) begin
				// Any one ends the run and clears the loss
				zero_cnt_next = LOSS_CNT_RST;
				loss_next = 1'b0;
			end else if (zero_cnt_reg != LOSS_ZEROS_EXT) begin
				zero_cnt_next = zero_cnt_reg + 13'h0001;
			end
		end
		// Compare on the count, so a threshold change acts at once
		if (zero_cnt_next >= limit) begin
			loss_next = 1'b1;
		end
	end

	// State registers
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			zero_cnt_reg <= LOSS_CNT_RST;
			loss_reg <= LOSS_RST;
		end else begin
			zero_cnt_reg <= zero_cnt_next;
			loss_reg <= loss_next;
		end
	end

	assign receive_signal_loss = loss_reg;

endmodule : liugc_loss_det

/* File: design/liugc_pkg.sv */
// Purpose: Shared constants for the global line-interface control block
// Assumes: Eight E1 channels, 8-bit register port with 12-bit addresses
// Notes:   Offsets are byte addresses on the configuration port
package liugc_pkg;

	// Channel count and port widths
	localparam int unsigned NUM_CHAN   = 8;
	localparam int unsigned ADDR_W     = 12;
	localparam int unsigned DATA_W     = 8;

	// Register offsets
	localparam logic [11:0] GLC_ONE_OFS   = 12'hfe1;
	localparam logic [11:0] GLC_TWO_OFS   = 12'hfe2;
	localparam logic [11:0] GLC_THREE_OFS = 12'hfe4;
	localparam logic [11:0] IRQ_STAT_OFS  = 12'hfe8;
	localparam logic [11:0] IRQ_MASK_OFS  = 12'hfe9;
	localparam logic [11:0] LOSS_STAT_OFS = 12'hfea;

	// Reset values
	localparam logic [7:0] GLC_ONE_RST   = 8'h00;
	localparam logic [7:0] GLC_TWO_RST   = 8'h00;
	localparam logic [7:0] GLC_THREE_RST = 8'h00;
	localparam logic [7:0] IRQ_STAT_RST  = 8'h00;
	localparam logic [7:0] IRQ_MASK_RST  = 8'h00;

	// Field positions in global_line_control_one
	localparam int unsigned OUTPUT_TRISTATE_TEST_BIT    = 0;
	localparam int unsigned EXTENDED_LOSS_THRESHOLD_BIT = 1;
	localparam int unsigned RECEIVE_MUTE_ON_LOSS_BIT    = 2;
	localparam int unsigned ARB_PULSE_ENABLE_BIT        = 3;
	localparam int unsigned RX_TIMING_GLOBAL_BIT        = 6;
	localparam int unsigned TX_TIMING_GLOBAL_BIT        = 7;

	// Per-channel base of the pulse segment registers (channel in top nibble)
	localparam logic [11:0] ARB_SEG_BASE_LOW = 12'hf08;

	// Consecutive-zero counts for loss declaration
	localparam int unsigned LOSS_CNT_W       = 13;
	localparam logic [12:0] LOSS_ZEROS_NORM  = 13'h00af;
	localparam logic [12:0] LOSS_ZEROS_EXT   = 13'h1000;
	localparam logic [12:0] LOSS_CNT_RST     = 13'h0000;

	// Channel register reset values
	localparam logic LOSS_RST = 1'b0;
	localparam logic DATA_RST = 1'b0;

endpackage : liugc_pkg

/* File: design/liugc_top.sv */
// Purpose: Global line-interface control registers for eight E1 channels
// Assumes: One clock, configuration port with one-cycle strobes
// Notes:   Loss events raise sticky interrupt bits, write one to clear
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
module liugc_top
	import liugc_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// Configuration port
	input  wire logic [11:0] cfg_addr,
	input  wire logic [7:0]  cfg_wdata,
	input  wire logic        cfg_wr_stb,
	input  wire logic        cfg_rd_stb,
	output logic      [7:0]  cfg_rdata,
	// Recovered receive data per channel
	input  wire logic [7:0]  rx_rec_data,
	input  wire logic [7:0]  rx_rec_valid,
	// Receive data toward the framer
	output logic      [7:0]  rx_framer_data,
	output logic      [7:0]  receive_signal_loss,
	// Transmit line pins
	input  wire logic [7:0]  tx_pos_in,
	input  wire logic [7:0]  tx_neg_in,
	output logic      [7:0]  tx_pos_o,
	output logic      [7:0]  tx_neg_o,
	output logic      [7:0]  tx_pin_oe,
	// Transmit shaping and timing controls
	output logic      [7:0]  tx_arb_pulse_mode,
	output logic             tx_timing_global,
	output logic             rx_timing_global,
	// Interrupt
	output logic             irq
);

	// Block structure
	// The configuration port writes five storage registers and reads six
	// addresses. Control one fans out to all eight channels at once, so a
	// single write changes the threshold, mute, pin release and shaping
	// mode of every channel on the same clock edge. There is no per-channel
	// override of these bits here; per-channel controls live elsewhere.
	// Control two and control three are plain storage. Control two bit
	// seven must be written as zero by software; the hardware keeps what is
	// written so that a faulty driver can be spotted by reading it back.
	//
	// Hazards worth knowing
	// A read strobe returns data one cycle later and only then; the read
	// data register returns to zero otherwise, so a master that samples
	// late sees zero rather than stale data.
	// The status register is write-one-to-clear. A loss onset that falls in
	// the cycle of the clearing write still sets its bit, so no event is
	// ever lost to a race with software.
	// The pin release bit acts combinationally on the output enables. The
	// rails themselves stay registered and keep following the framer, so
	// leaving the test mode restores the current data at once.

	// Write decode, shared by every register
	function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs,
		input logic stb);
		hit = stb && (a == ofs);
	endfunction : hit

	// Register state
	logic [7:0] glc_one_reg;    // Global control one
	logic [7:0] glc_one_next;
	logic [7:0] glc_two_reg;    // Global control two
	logic [7:0] glc_two_next;
	logic [7:0] glc_three_reg;  // Global control three
	logic [7:0] glc_three_next;
	logic [7:0] irq_stat_reg;   // Sticky loss events
	logic [7:0] irq_stat_next;
	logic [7:0] irq_mask_reg;   // Interrupt enables
	logic [7:0] irq_mask_next;
	logic [7:0] rdata_reg;      // Read answer
	logic [7:0] rdata_next;
	logic [7:0] loss_prev_reg;  // Loss one cycle ago
	logic [7:0] loss_prev_next;

	// Internal wires
	logic [7:0] loss_now;       // Current loss per channel
	logic [7:0] loss_rise;      // New loss declarations
	logic       ctl_mute;       // Mute enable
	logic       ctl_ext;        // Extended threshold
	logic       ctl_test;       // Pin release
	logic       ctl_arb;        // Arbitrary pulse shaping

	// Field extraction from control one
	assign ctl_mute = glc_one_reg[RECEIVE_MUTE_ON_LOSS_BIT];
	assign ctl_ext  = glc_one_reg[EXTENDED_LOSS_THRESHOLD_BIT];
	assign ctl_test = glc_one_reg[OUTPUT_TRISTATE_TEST_BIT];
	assign ctl_arb  = glc_one_reg[ARB_PULSE_ENABLE_BIT];

	// Per-channel loss detection and output stages
	// Each channel gets its own detector, so a quiet channel never masks a
	// live one. The shared threshold bit means a change of threshold acts
	// on every channel in the same cycle, and a channel whose run already
	// passes the shorter limit declares loss as soon as that limit is used.
	// The mute stage reads the registered loss state, so muting begins one
	// cycle after loss is declared and ends one cycle after it clears.
	genvar ch;
	generate
		for (ch = 0; ch < NUM_CHAN; ch = ch + 1) begin : g_chan
			// One detector per channel, all share the threshold bit
			liugc_loss_det u_loss (
				.clk                     (clk),
				.sys_rst                 (sys_rst),
				.rx_data                 (rx_rec_data[ch]),
				.rx_valid                (rx_rec_valid[ch]),
				.extended_loss_threshold (ctl_ext),
				.receive_signal_loss     (loss_now[ch])
			);
			// Mute and pin stage, same controls on every channel
			liugc_chan_out u_out (
				.clk                  (clk),
				.sys_rst              (sys_rst),
				.receive_mute_on_loss (ctl_mute),
				.receive_signal_loss  (loss_now[ch]),
				.output_tristate_test (ctl_test),
				.rx_data              (rx_rec_data[ch]),
				.rx_framer_data       (rx_framer_data[ch]),
				.tx_pos_in            (tx_pos_in[ch]),
				.tx_neg_in            (tx_neg_in[ch]),
				.tx_pos_o             (tx_pos_o[ch]),
				.tx_neg_o             (tx_neg_o[ch]),
				.tx_pin_oe            (tx_pin_oe[ch])
			);
		end
	endgenerate

	// Loss onset marks an interrupt event
	// Only the rising edge counts: a loss that persists raises one event,
	// and software that clears the status bit is not interrupted again
	// until the channel recovers and loses signal once more.
	assign loss_rise = loss_now & ~loss_prev_reg;

	// Control register writes
	// Addresses are compared in full, so aliases of these registers do not
	// exist; writes to unmapped addresses fall through and change nothing.
	// Strobes may come back to back, each write lands on its own edge.
	always_comb begin
		glc_one_next = glc_one_reg;
		glc_two_next = glc_two_reg;
		glc_three_next = glc_three_reg;
		irq_mask_next = irq_mask_reg;
		// Control one: every bit stored and read back
		if (hit(cfg_addr, GLC_ONE_OFS, cfg_wr_stb)) begin
			glc_one_next = cfg_wdata;
		end
		// Control two: stored as written; bit seven is kept at zero by software
		if (hit(cfg_addr, GLC_TWO_OFS, cfg_wr_stb)) begin
			glc_two_next = cfg_wdata;
		end
		// Control three: storage with no effect anywhere
		if (hit(cfg_addr, GLC_THREE_OFS, cfg_wr_stb)) begin
			glc_three_next = cfg_wdata;
		end
		// Interrupt mask
		if (hit(cfg_addr, IRQ_MASK_OFS, cfg_wr_stb)) begin
			irq_mask_next = cfg_wdata;
		end
	end

	// Control registers
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			glc_one_reg <= GLC_ONE_RST;
			glc_two_reg <= GLC_TWO_RST;
			glc_three_reg <= GLC_THREE_RST;
			irq_mask_reg <= IRQ_MASK_RST;
		end else begin
			glc_one_reg <= glc_one_next;
			glc_two_reg <= glc_two_next;
			glc_three_reg <= glc_three_next;
			irq_mask_reg <= irq_mask_next;
		end
	end

	// Sticky status: a new event wins over a same-cycle clear
	always_comb begin
		irq_stat_next = irq_stat_reg;
		if (hit(cfg_addr, IRQ_STAT_OFS, cfg_wr_stb)) begin
			irq_stat_next = irq_stat_reg & ~cfg_wdata;
		end
		irq_stat_next = irq_stat_next | loss_rise;
		loss_prev_next = loss_now;
	end

	// Status registers
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_stat_reg <= IRQ_STAT_RST;
			loss_prev_reg <= IRQ_STAT_RST;
		end else begin
			irq_stat_reg <= irq_stat_next;
			loss_prev_reg <= loss_prev_next;
		end
	end

	// Read mux; the answer stands only in the cycle after the strobe
	// Reads have no side effects: status bits are cleared only by writes,
	// so a debugger polling the port cannot disturb pending events.
	// The live loss address shows the detectors directly, which lets
	// software tell an old event from a condition that still stands.
	always_comb begin
		rdata_next = 8'h00;
		if (cfg_rd_stb) begin
			case (cfg_addr)
				GLC_ONE_OFS: begin
					rdata_next = glc_one_reg;
				end
				GLC_TWO_OFS: begin
					rdata_next = glc_two_reg;
				end
				GLC_THREE_OFS: begin
					rdata_next = glc_three_reg;
				end
				IRQ_STAT_OFS: begin
					rdata_next = irq_stat_reg;
				end
				IRQ_MASK_OFS: begin
					rdata_next = irq_mask_reg;
				end
				LOSS_STAT_OFS: begin
					// Live loss state, not sticky
					rdata_next = loss_now;
				end
				default: begin
					// Unmapped addresses read as zero
					rdata_next = 8'h00;
				end
			endcase
		end
	end

	// Read data register
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdata_reg <= 8'h00;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	// Outputs
	// Everything here is either a register or a plain decode of registers,
	// so no output depends combinationally on the configuration port.
	assign cfg_rdata = rdata_reg;
	assign receive_signal_loss = loss_now;
	assign tx_arb_pulse_mode = {NUM_CHAN{ctl_arb}};
	assign tx_timing_global = glc_one_reg[TX_TIMING_GLOBAL_BIT];
	assign rx_timing_global = glc_one_reg[RX_TIMING_GLOBAL_BIT];
	// Level interrupt while any unmasked event is pending
	assign irq = |(irq_stat_reg & irq_mask_reg);

endmodule : liugc_top

/* File: tb/liugc_top_asserts.sv */
// Purpose: Checker for the global line control block
// Assumes: Shadow copies follow port writes
// Notes:   Sees only the top module ports
`timescale 1ns/1ps
module liugc_top_chk
	import liugc_pkg::*;
(
	// Clock and reset
	input wire logic        clk,
	input wire logic        sys_rst,
	// Configuration port
	input wire logic [11:0] cfg_addr,
	input wire logic [7:0]  cfg_wdata,
	input wire logic        cfg_wr_stb,
	input wire logic        cfg_rd_stb,
	input wire logic [7:0]  cfg_rdata,
	// Line side
	input wire logic [7:0]  rx_rec_data,
	input wire logic [7:0]  rx_rec_valid,
	input wire logic [7:0]  rx_framer_data,
	input wire logic [7:0]  receive_signal_loss,
	input wire logic [7:0]  tx_pin_oe,
	input wire logic [7:0]  tx_arb_pulse_mode,
	input wire logic        irq
);
	logic [7:0]  ctl_q;     // Shadow of control one
	logic [7:0]  thr_q;     // Shadow of control three
	logic [7:0]  msk_q;     // Shadow of mask
	logic [7:0]  los_q;     // Modelled loss
	logic [12:0] zc_q [8];  // Zero run per channel

	// Shadows and loss model; a one clears the run
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctl_q <= 8'h00;
			thr_q <= 8'h00;
			msk_q <= 8'h00;
			los_q <= 8'h00;
			for (int i = 0; i < 8; i++) zc_q[i] <= 13'h0000;
		end else begin
			if (cfg_wr_stb && cfg_addr == GLC_ONE_OFS) ctl_q <= cfg_wdata;
			if (cfg_wr_stb && cfg_addr == GLC_THREE_OFS) thr_q <= cfg_wdata;
			if (cfg_wr_stb && cfg_addr == IRQ_MASK_OFS) msk_q <= cfg_wdata;
			for (int i = 0; i < 8; i++) begin
				if (rx_rec_valid[i] && rx_rec_data[i]) begin
					zc_q[i] <= 13'h0000;
					los_q[i] <= 1'b0;
				end else if (rx_rec_valid[i]) begin
					// Saturate so no wrap
					if (zc_q[i] != LOSS_ZEROS_EXT) zc_q[i] <= zc_q[i] + 13'h0001;
					if (zc_q[i] + 13'h0001 >= (ctl_q[1] ? LOSS_ZEROS_EXT : LOSS_ZEROS_NORM))
						los_q[i] <= 1'b1;
				end
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	rd_idle_a: assert property (!$past(cfg_rd_stb) |-> cfg_rdata == 8'h00)
		else $error("read data not idle");
	rd_one_a: assert property (cfg_rd_stb && cfg_addr == GLC_ONE_OFS
		|=> cfg_rdata == ctl_q) else $error("control one readback");
	rd_three_a: assert property (cfg_rd_stb && cfg_addr == GLC_THREE_OFS
		|=> cfg_rdata == thr_q) else $error("control three readback");
	arb_mode_a: assert property (tx_arb_pulse_mode == {8{ctl_q[3]}})
		else $error("arbitrary mode wrong");
	pin_oe_a: assert property (tx_pin_oe == {8{~ctl_q[0]}})
		else $error("pin enable wrong");
	rx_mute_a: assert property (rx_framer_data ==
		$past(rx_rec_data & ~(receive_signal_loss & {8{ctl_q[2]}}))) else $error("mute wrong");
	loss_model_a: assert property (receive_signal_loss == los_q)
		else $error("loss state wrong");
	irq_rise_a: assert property (|(receive_signal_loss & ~$past(receive_signal_loss) & msk_q)
		|=> irq [*2]) else $error("irq not raised");
	irq_mask_a: assert property (msk_q == 8'h00 |-> !irq)
		else $error("irq while masked");

	// Main scenarios
	cover property ($rose(receive_signal_loss[0]));
	cover property ($rose(irq));
	cover property (cfg_rd_stb && cfg_addr == GLC_ONE_OFS);
endmodule : liugc_top_chk

bind liugc_top liugc_top_chk chk (.clk(clk), .sys_rst(sys_rst), .cfg_addr(cfg_addr),
	.cfg_wdata(cfg_wdata), .cfg_wr_stb(cfg_wr_stb), .cfg_rd_stb(cfg_rd_stb),
	.cfg_rdata(cfg_rdata), .rx_rec_data(rx_rec_data), .rx_rec_valid(rx_rec_valid),
	.rx_framer_data(rx_framer_data), .receive_signal_loss(receive_signal_loss),
	.tx_pin_oe(tx_pin_oe), .tx_arb_pulse_mode(tx_arb_pulse_mode), .irq(irq));

/* File: tb/test_liugc_top.sv */
// Purpose: Self-checking bench for global line control
// Assumes: Inputs change by non-blocking assignment at rising edges; tx_pos_in and tx_neg_in 1 ns after one
// Notes:   Loss runs use the full zero counts
`timescale 1ns/1ps
module test_liugc_top
	import liugc_pkg::*;
;
	logic        clk, sys_rst, cfg_wr_stb, cfg_rd_stb;     // Clock, reset, strobes
	logic [11:0] cfg_addr;                                  // Register address
	logic [7:0]  cfg_wdata, cfg_rdata, rx_rec_data, rx_rec_valid, rx_framer_data;
	logic [7:0]  receive_signal_loss, tx_pos_in, tx_neg_in, tx_pos_o, tx_neg_o;
	logic [7:0]  tx_pin_oe, tx_arb_pulse_mode, d;           // Pins, scratch value
	logic        tx_timing_global, rx_timing_global, irq;  // Status outputs
	int          miscompares, compares, seed;               // Counters, seed

	liugc_top dut (.clk(clk), .sys_rst(sys_rst), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
		.cfg_wr_stb(cfg_wr_stb), .cfg_rd_stb(cfg_rd_stb), .cfg_rdata(cfg_rdata),
		.rx_rec_data(rx_rec_data), .rx_rec_valid(rx_rec_valid),
		.rx_framer_data(rx_framer_data), .receive_signal_loss(receive_signal_loss),
		.tx_pos_in(tx_pos_in), .tx_neg_in(tx_neg_in), .tx_pos_o(tx_pos_o),
		.tx_neg_o(tx_neg_o), .tx_pin_oe(tx_pin_oe), .tx_arb_pulse_mode(tx_arb_pulse_mode),
		.tx_timing_global(tx_timing_global), .rx_timing_global(rx_timing_global), .irq(irq));

	// Free-running 250 MHz clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// Compare and count
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// One-cycle write
	task automatic wr(input logic [11:0] a, input logic [7:0] v);
		@(posedge clk);
		cfg_addr <= a;
		cfg_wdata <= v;
		cfg_wr_stb <= 1'b1;
		@(posedge clk);
		cfg_wr_stb <= 1'b0;
	endtask : wr

	// One-cycle read, data checked in the next cycle only
	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		@(posedge clk);
		cfg_addr <= a;
		cfg_rd_stb <= 1'b1;
		@(posedge clk);
		cfg_rd_stb <= 1'b0;
		#1 check("cfg_rdata", cfg_rdata, e);
	endtask : rd

	// Receive bits for n cycles, then valid drops
	task automatic bits(input int n, input logic [7:0] dv, input logic [7:0] vv);
		repeat (n) begin
			@(posedge clk);
			rx_rec_data <= dv;
			rx_rec_valid <= vv;
		end
		@(posedge clk);
		rx_rec_valid <= 8'h00;
	endtask : bits

	// Verdict
	task automatic test_done;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : test_done

	// Watchdog, about four times the expected run
	initial begin
		#80000;
		miscompares++;
		test_done;
	end

	// Main sequence
	initial begin
		{cfg_addr, cfg_wdata, cfg_wr_stb, cfg_rd_stb} = '0;
		{rx_rec_data, rx_rec_valid, tx_pos_in, tx_neg_in} = '0;
		seed = 66;
		sys_rst = 1'b1;
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		rd(GLC_ONE_OFS, 8'h00);
		rd(GLC_TWO_OFS, 8'h00);
		rd(GLC_THREE_OFS, 8'h00);
		rd(12'h123, 8'h00);
		check("tx_pin_oe", tx_pin_oe, 8'hff);
		check("irq", irq, 8'h00);
		check("rx_framer_data", rx_framer_data, 8'h00);
		$display("reset test done");
		// Random storage, controls and line traffic
		repeat (20) begin
			d = $random(seed);
			wr(GLC_TWO_OFS, d & 8'h7f);
			wr(GLC_THREE_OFS, ~d);
			wr(12'h123, d);
			rd(GLC_TWO_OFS, d & 8'h7f);
			rd(GLC_THREE_OFS, ~d);
			rd(12'h123, 8'h00);
			wr(GLC_ONE_OFS, d & 8'hcf);
			#1 check("tx_arb_pulse_mode", tx_arb_pulse_mode, {8{d[3]}});
			check("tx_pin_oe", tx_pin_oe, {8{~d[0]}});
			check("tx_timing_global", tx_timing_global, d[7]);
			check("rx_timing_global", rx_timing_global, d[6]);
			rd(GLC_ONE_OFS, d & 8'hcf);
			tx_pos_in <= d;
			tx_neg_in <= ~d;
			bits(4, $random(seed), $random(seed));
			check("tx_pos_o", tx_pos_o, d);
			check("tx_neg_o", tx_neg_o, ~d);
		end
		$display("register test done");
		// Normal threshold, mute and interrupt
		wr(GLC_ONE_OFS, 8'h04);
		wr(IRQ_MASK_OFS, 8'h01);
		bits(1, 8'hff, 8'hff);
		bits(174, 8'h00, 8'h01);
		#1 check("loss", receive_signal_loss, 8'h00);
		bits(1, 8'h00, 8'h01);
		#1 check("loss", receive_signal_loss, 8'h01);
		rd(LOSS_STAT_OFS, 8'h01);
		rd(IRQ_MASK_OFS, 8'h01);
		bits(1, 8'hff, 8'h00);
		#1 check("rx_framer_data", rx_framer_data, 8'hfe);
		check("irq", irq, 8'h01);
		wr(GLC_ONE_OFS, 8'h00);
		bits(1, 8'hff, 8'h00);
		#1 check("rx_framer_data", rx_framer_data, 8'hff);
		rd(IRQ_STAT_OFS, 8'h01);
		wr(IRQ_STAT_OFS, 8'h01);
		rd(IRQ_STAT_OFS, 8'h00);
		check("irq", irq, 8'h00);
		bits(1, 8'h01, 8'h01);
		#1 check("loss", receive_signal_loss, 8'h00);
		$display("loss test done");
		// Extended threshold on every channel at once
		wr(GLC_ONE_OFS, 8'h02);
		bits(4095, 8'h00, 8'hff);
		#1 check("loss", receive_signal_loss, 8'h00);
		bits(1, 8'h00, 8'hff);
		#1 check("loss", receive_signal_loss, 8'hff);
		$display("extended test done");
		test_done;
	end
endmodule : test_liugc_top
